// >>> srb_pkg.sv
// Package for the status readback register bank.
// Assumes a 16-bit register address space, 8-bit data, one system clock.
package srb_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [15:0] ADDR_UPDATE = 16'h000F;
  localparam logic [15:0] ADDR_LOOP0_BASE = 16'h0A20;
  localparam logic [15:0] LOOP2_OFFSET = 16'h0040;
  localparam logic [15:0] LOOP3_OFFSET = 16'h0060;
  localparam logic [15:0] ADDR_TRIM_LOW = 16'h0B00;
  localparam logic [15:0] ADDR_TRIM_HIGH = 16'h0B01;
  localparam logic [15:0] ADDR_STAT_FIRST = 16'h0D00;
  localparam logic [15:0] ADDR_STAT_LAST = 16'h0D05;
  localparam logic [15:0] ADDR_MEM_STATUS = 16'h0D00;
  localparam logic [15:0] ADDR_CLK_STATUS = 16'h0D01;
  localparam logic [15:0] ADDR_IRQ_STATUS = 16'h0E00;
  localparam logic [15:0] ADDR_IRQ_MASK = 16'h0E01;
  localparam logic [2:0] CTRL_REG_COUNT = 3'h5;

  // ----------------------------------------------------------------------
  // Field values
  // ----------------------------------------------------------------------
  localparam logic [7:0] UPDATE_VALUE = 8'h01;
  localparam logic [7:0] TRIM_LOW_RESET = 8'h00;
  localparam logic [1:0] TRIM_HIGH_RESET = 2'h0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int MEM_CRC_BIT = 3;
  localparam int MEM_FAULT_BIT = 2;
  localparam int MEM_DOWNLOAD_BIT = 1;
  localparam int MEM_UPLOAD_BIT = 0;
  localparam int CLK_LOCKED_BASE = 4;
  localparam int CLK_CAL_BIT = 2;
  localparam int CLK_STABLE_BIT = 1;
  localparam int CLK_LOCK_BIT = 0;
  // Interrupt event bits: crc, fault, loss of system clock lock.
  localparam int IRQ_CRC_BIT = 0;
  localparam int IRQ_FAULT_BIT = 1;
  localparam int IRQ_UNLOCK_BIT = 2;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

endpackage : srb_pkg

// >>> srb_bank.sv
// Status readback register bank with mirrored loop controls and trim.
// Assumes status inputs already sit in the system clock domain.
module srb_bank
  import srb_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_mem_crc_err,
  input wire logic i_mem_err,
  input wire logic i_mem_download,
  input wire logic i_mem_upload,
  input wire logic i_system_clock_lock,
  input wire logic i_system_clock_cal,
  input wire logic i_system_clock_stable,
  input wire logic [3:0] i_analog_loop_lock,
  input wire logic [3:0] i_digital_loop_lock,
  output logic [7:0] o_rdata,
  output logic [9:0] o_regulator_trim,
  output logic [7:0] o_loop2_ctrl [5],
  output logic [7:0] o_loop3_ctrl [5],
  output logic o_irq
);

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  logic loop2_hit;
  logic loop3_hit;
  logic [7:0] loop2_sel;
  logic [7:0] loop3_sel;
  logic update_stb;

  assign update_stb = i_wr && i_addr == ADDR_UPDATE
                      && i_wdata == UPDATE_VALUE;

  // ----------------------------------------------------------------------
  // Mirrored loop controls
  // ----------------------------------------------------------------------
  // Only storage is kept here; the loop logic interprets the bits, so a
  // self-clearing control bit reads back as written until rewritten.
  srb_ctrl_copy #(
    .BASE(16'(ADDR_LOOP0_BASE + LOOP2_OFFSET))
  )
  srb_ctrl_copy_loop2 (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .o_hit(loop2_hit),
    .o_sel(loop2_sel),
    .o_ctrl(o_loop2_ctrl)
  );

  srb_ctrl_copy #(
    .BASE(16'(ADDR_LOOP0_BASE + LOOP3_OFFSET))
  )
  srb_ctrl_copy_loop3 (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .o_hit(loop3_hit),
    .o_sel(loop3_sel),
    .o_ctrl(o_loop3_ctrl)
  );

  // ----------------------------------------------------------------------
  // Regulator trim
  // ----------------------------------------------------------------------
  // Mixed values are stored as written; software owns their validity.
  logic [7:0] trim_low_q;
  logic [1:0] trim_high_q;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      trim_low_q <= TRIM_LOW_RESET;
    end
    else if (i_wr && i_addr == ADDR_TRIM_LOW)
    begin
      trim_low_q <= i_wdata;
    end
  end

  // Bits 7:2 of the high register are reserved: not stored, read as zero.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      trim_high_q <= TRIM_HIGH_RESET;
    end
    else if (i_wr && i_addr == ADDR_TRIM_HIGH)
    begin
      trim_high_q <= i_wdata[1:0];
    end
  end

  assign o_regulator_trim = {trim_high_q, trim_low_q};

  // ----------------------------------------------------------------------
  // Status snapshot
  // ----------------------------------------------------------------------
  // Status is sampled only on the update strobe, so a read shows the state
  // at the last strobe, not the live inputs.
  logic [7:0] mem_live;
  logic [7:0] clk_live;
  logic [7:0] mem_stat_q;
  logic [7:0] clk_stat_q;

  always_comb
  begin
    mem_live = 8'h00;
    mem_live[MEM_CRC_BIT] = i_mem_crc_err;
    mem_live[MEM_FAULT_BIT] = i_mem_err | i_mem_crc_err;
    mem_live[MEM_DOWNLOAD_BIT] = i_mem_download;
    mem_live[MEM_UPLOAD_BIT] = i_mem_upload;
  end

  always_comb
  begin
    clk_live = 8'h00;
    for (int n = 0; n < 4; n++)
    begin
      clk_live[CLK_LOCKED_BASE + n] = i_system_clock_lock
        & i_analog_loop_lock[n] & i_digital_loop_lock[n];
    end
    clk_live[CLK_CAL_BIT] = i_system_clock_cal;
    clk_live[CLK_STABLE_BIT] = i_system_clock_stable;
    clk_live[CLK_LOCK_BIT] = i_system_clock_lock;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      mem_stat_q <= 8'h00;
    end
    else if (update_stb)
    begin
      mem_stat_q <= mem_live;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      clk_stat_q <= 8'h00;
    end
    else if (update_stb)
    begin
      clk_stat_q <= clk_live;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------
  logic [2:0] irq_stat_q;
  logic [2:0] irq_mask_q;
  // Event sources: memory checksum error, the memory error input alone, and a fall
  // of the system clock lock.
  logic [2:0] irq_evt;
  logic [2:0] irq_clr;
  logic lock_prev_q;

  // The previous lock level resets low, so a lock that is already low
  // when reset ends raises no false unlock event.

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      lock_prev_q <= 1'b0;
    end
    else
    begin
      lock_prev_q <= i_system_clock_lock;
    end
  end

  always_comb
  begin
    irq_evt = 3'h0;
    irq_evt[IRQ_CRC_BIT] = i_mem_crc_err;
    irq_evt[IRQ_FAULT_BIT] = i_mem_err;
    irq_evt[IRQ_UNLOCK_BIT] = lock_prev_q & ~i_system_clock_lock;
  end

  // Writing a one to a status bit clears that bit only.
  assign irq_clr = (i_wr && i_addr == ADDR_IRQ_STATUS) ? i_wdata[2:0]
                                                        : 3'h0;

  for (genvar b = 0; b < $bits(irq_evt); b++)
  begin : g_irq
    srb_sticky srb_sticky_bit (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_set(irq_evt[b]),
      .i_clear(irq_clr[b]),
      .o_flag(irq_stat_q[b])
    );
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      irq_mask_q <= IRQ_MASK_RESET;
    end
    else if (i_wr && i_addr == ADDR_IRQ_MASK)
    begin
      irq_mask_q <= i_wdata[2:0];
    end
  end

  assign o_irq = |(irq_stat_q & irq_mask_q);

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  // Writes to the status range match no storage, hence are ignored.
  logic [7:0] rd_d;

  always_comb
  begin
    rd_d = 8'h00;
    if (loop2_hit)
    begin
      rd_d = loop2_sel;
    end
    else if (loop3_hit)
    begin
      rd_d = loop3_sel;
    end
    else
    begin
      unique case (i_addr)
        ADDR_TRIM_LOW: rd_d = trim_low_q;
        ADDR_TRIM_HIGH: rd_d = {6'h00, trim_high_q};
        ADDR_MEM_STATUS: rd_d = mem_stat_q;
        ADDR_CLK_STATUS: rd_d = clk_stat_q;
        ADDR_IRQ_STATUS: rd_d = {5'h00, irq_stat_q};
        ADDR_IRQ_MASK: rd_d = {5'h00, irq_mask_q};
        default: rd_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      o_rdata <= 8'h00;
    end
    else if (i_rd)
    begin
      o_rdata <= rd_d;
    end
    else
    begin
      o_rdata <= 8'h00;
    end
  end

endmodule // srb_bank

// ----------------------------------------------------------------------
// Loop channel control copy
// ----------------------------------------------------------------------
// Every loop channel has the same run of control bytes at its own base,
// so one copy of this module serves each mirrored channel and they can
// never drift apart in layout or reset value.
module srb_ctrl_copy
  import srb_pkg::*;
#(
  parameter logic [15:0] BASE = ADDR_LOOP0_BASE
)
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  output logic o_hit,
  output logic [7:0] o_sel,
  output logic [7:0] o_ctrl [CTRL_REG_COUNT]
);

  logic [15:0] rel;
  logic [2:0] idx;
  logic [7:0] ctrl_q [CTRL_REG_COUNT];

  // The offset is taken by subtraction, so addresses below the base wrap
  // to large values and can never hit.
  assign rel = i_addr - BASE;
  assign o_hit = rel < {13'h0000, CTRL_REG_COUNT};
  assign idx = rel[2:0];

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      for (int k = 0; k < CTRL_REG_COUNT; k++)
      begin
        ctrl_q[k] <= CTRL_RESET;
      end
    end
    else if (i_wr && o_hit)
    begin
      ctrl_q[idx] <= i_wdata;
    end
  end

  assign o_sel = o_hit ? ctrl_q[idx] : 8'h00;
  assign o_ctrl = ctrl_q;

endmodule // srb_ctrl_copy

// ----------------------------------------------------------------------
// Sticky event flag
// ----------------------------------------------------------------------
module srb_sticky
  import srb_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_set,
  input wire logic i_clear,
  output logic o_flag
);

  // A set in the clearing cycle wins, so an event is never lost.
  // A level source sets the flag again each cycle until it goes away.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      o_flag <= 1'b0;
    end
    else if (i_set)
    begin
      o_flag <= 1'b1;
    end
    else if (i_clear)
    begin
      o_flag <= 1'b0;
    end
  end

endmodule // srb_sticky

// >>> srb_bank_chk.sv
// Checker for the srb_bank register port and status snapshot.
// Assumes it is bound to srb_bank and sees only that module's ports.
module srb_bank_chk
  import srb_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_mem_crc_err,
  input wire logic i_mem_err,
  input wire logic i_mem_download,
  input wire logic i_mem_upload,
  input wire logic i_system_clock_lock,
  input wire logic i_system_clock_cal,
  input wire logic i_system_clock_stable,
  input wire logic [3:0] i_analog_loop_lock,
  input wire logic [3:0] i_digital_loop_lock,
  input wire logic [7:0] o_rdata,
  input wire logic [9:0] o_regulator_trim,
  input wire logic [7:0] o_loop2_ctrl [5],
  input wire logic [7:0] o_loop3_ctrl [5]
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  logic upd;
  logic [7:0] mem_q, clk_q;
  assign upd = i_wr && i_addr == ADDR_UPDATE && i_wdata == UPDATE_VALUE;
  // Shadow snapshot; it moves only on the update strobe, so writes to
  // the status range can never disturb it.
  always_ff @(posedge i_clk_sys)
    if (i_rst)
    begin
      mem_q <= 8'h00;
      clk_q <= 8'h00;
    end
    else if (upd)
    begin
      mem_q <= {4'h0, i_mem_crc_err, i_mem_err | i_mem_crc_err,
        i_mem_download, i_mem_upload};
      clk_q <= {i_analog_loop_lock & i_digital_loop_lock &
        {4{i_system_clock_lock}}, 1'b0, i_system_clock_cal,
        i_system_clock_stable, i_system_clock_lock};
    end
  trim_lo_a: assert property (i_wr && i_addr == ADDR_TRIM_LOW
    |=> o_regulator_trim[7:0] == $past(i_wdata)) else $error("trim low");
  trim_hi_a: assert property (i_wr && i_addr == ADDR_TRIM_HIGH
    |=> o_regulator_trim[9:8] == $past(i_wdata[1:0])) else $error("trim hi");
  trim_keep_a: assert property (
    !(i_wr && i_addr[15:1] == 15'h0580) |=> $stable(o_regulator_trim))
    else $error("trim moved");
  loop2_a: assert property (i_wr && i_addr == 16'h0A60 |=>
    o_loop2_ctrl[0] == $past(i_wdata)) else $error("loop2 ctrl");
  loop3_a: assert property (i_wr && i_addr == 16'h0A84 |=>
    o_loop3_ctrl[4] == $past(i_wdata)) else $error("loop3 ctrl");
  mem_stat_a: assert property (
    i_rd && i_addr == ADDR_MEM_STATUS |=> o_rdata == mem_q)
    else $error("memory status");
  lock_bits_a: assert property (
    i_rd && i_addr == ADDR_CLK_STATUS |=> o_rdata[7:4] == clk_q[7:4])
    else $error("lock bits");
  clk_bits_a: assert property (
    i_rd && i_addr == ADDR_CLK_STATUS |=> o_rdata[3:0] == clk_q[3:0])
    else $error("clock bits");
  upd_rd_c: cover property (upd ##1 i_rd && i_addr == ADDR_CLK_STATUS);
  trim_c: cover property (i_wr && i_addr == ADDR_TRIM_LOW && i_wdata[0]);
  ro_wr_c: cover property (i_wr && i_addr == ADDR_CLK_STATUS);
endmodule // srb_bank_chk

bind srb_bank srb_bank_chk srb_bank_chk_inst (.*);

// >>> test_srb_bank.sv
// Testbench for srb_bank: register port scenarios and a verdict.
// Assumes srb_pkg, srb_bank and the bound checker are compiled first.
module test_srb_bank
  import srb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic crc = 1'b0, err = 1'b0, dn = 1'b0, up = 1'b0;
  logic slk = 1'b0, cal = 1'b0, stb = 1'b0, irq;
  logic [3:0] alk = 4'h0, dlk = 4'h0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, rdata;
  logic [9:0] trim;
  logic [7:0] l2 [5];
  logic [7:0] l3 [5];
  int err_count = 0, check_count = 0;
  srb_bank srb_bank_inst (.i_clk_sys(clk), .i_rst(rst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_mem_crc_err(crc),
    .i_mem_err(err), .i_mem_download(dn), .i_mem_upload(up),
    .i_system_clock_lock(slk), .i_system_clock_cal(cal),
    .i_system_clock_stable(stb), .i_analog_loop_lock(alk),
    .i_digital_loop_lock(dlk), .o_rdata(rdata), .o_regulator_trim(trim),
    .o_loop2_ctrl(l2), .o_loop3_ctrl(l3), .o_irq(irq));
  initial
    forever #25 clk = ~clk;
  // --------------------
  // Bus tasks
  // --------------------
  task automatic chk(input string n, input logic [9:0] e,
    input logic [9:0] s);
    check_count++;
    if (s !== e)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  // Read data stand only in the cycle after the strobe, so look there.
  task automatic reg_rd(input logic [15:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", {2'b00, e}, {2'b00, rdata});
    @(posedge clk);
  endtask
  task automatic upd_rd(input logic [15:0] a, input logic [7:0] e);
    addr <= ADDR_UPDATE;
    wdata <= UPDATE_VALUE;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    reg_rd(a, e);
  endtask
  task automatic report_and_stop();
    if (err_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic t_trim();
    chk("trim", 10'h000, trim);
    reg_wr(ADDR_TRIM_LOW, 8'hFF);
    reg_wr(ADDR_TRIM_HIGH, 8'h03);
    chk("trim", 10'h3FF, trim);
    reg_rd(ADDR_TRIM_HIGH, 8'h03);
    reg_wr(ADDR_TRIM_HIGH, 8'h00);
    reg_wr(ADDR_TRIM_LOW, 8'h00);
    chk("trim", 10'h000, trim);
  endtask
  task automatic t_loops();
    for (int i = 0; i < 5; i++)
    begin
      chk("loop2", 10'h000, {2'b00, l2[i]});
      chk("loop3", 10'h000, {2'b00, l3[i]});
      reg_wr(ADDR_LOOP0_BASE + LOOP2_OFFSET + 16'(i), 8'h5A ^ 8'(i));
      reg_wr(ADDR_LOOP0_BASE + LOOP3_OFFSET + 16'(i), 8'hA5 ^ 8'(i));
      chk("loop2", {2'b00, 8'h5A ^ 8'(i)}, {2'b00, l2[i]});
      chk("loop3", {2'b00, 8'hA5 ^ 8'(i)}, {2'b00, l3[i]});
      reg_rd(ADDR_LOOP0_BASE + LOOP2_OFFSET + 16'(i), 8'h5A ^ 8'(i));
      reg_rd(ADDR_LOOP0_BASE + LOOP3_OFFSET + 16'(i), 8'hA5 ^ 8'(i));
    end
  endtask
  task automatic t_status();
    {crc, err, dn, up} <= 4'hB;
    {slk, cal, stb} <= 3'b110;
    alk <= 4'hF;
    dlk <= 4'h6;
    upd_rd(ADDR_MEM_STATUS, 8'h0F);
    upd_rd(ADDR_CLK_STATUS, 8'h65);
    {crc, err, dn, up} <= 4'h4;
    {slk, cal, stb} <= 3'b001;
    reg_wr(ADDR_CLK_STATUS, 8'hFF);
    reg_rd(ADDR_CLK_STATUS, 8'h65);
    upd_rd(ADDR_MEM_STATUS, 8'h04);
    upd_rd(ADDR_CLK_STATUS, 8'h02);
    reg_rd(16'h0C00, 8'h00);
    {err, slk} <= 2'b01;
    for (int n = 0; n < 4; n++)
    begin
      alk <= 4'h1 << n;
      dlk <= 4'hF;
      upd_rd(ADDR_CLK_STATUS, {4'h1 << n, 4'h3});
      alk <= 4'hF;
      dlk <= ~(4'h1 << n);
      upd_rd(ADDR_CLK_STATUS, {~(4'h1 << n), 4'h3});
    end
  endtask
  task automatic t_irq();
    reg_wr(ADDR_IRQ_MASK, 8'h07);
    reg_wr(ADDR_IRQ_STATUS, 8'h07);
    chk("irq", 10'h000, {9'h000, irq});
    crc <= 1'b1;
    reg_wr(ADDR_IRQ_MASK, 8'h00);
    crc <= 1'b0;
    chk("irq", 10'h000, {9'h000, irq});
    reg_rd(ADDR_IRQ_STATUS, 8'h01);
    reg_wr(ADDR_IRQ_MASK, 8'h01);
    chk("irq", 10'h001, {9'h000, irq});
    reg_wr(ADDR_IRQ_STATUS, 8'h01);
    chk("irq", 10'h000, {9'h000, irq});
  endtask
  initial
  begin
    #100000;
    err_count++;
    report_and_stop();
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_trim();
    t_loops();
    t_status();
    t_irq();
    report_and_stop();
  end
endmodule // test_srb_bank
